// ---- hdl/fifo_reset_pkg.sv ----
package fifo_reset_pkg;

  // Queue shape defaults
  localparam int DEPTH_DEFAULT = 16;
  localparam int WIDTH_DEFAULT = 32;

  // Clear sequencing, in cycles of the one shared clock
  localparam int RESET_SYNC_CYCLES = 3;
  localparam int FULL_RELEASE_CYCLES = 5;
  localparam int WRITABLE_AFTER_ASSERT = 5;
  localparam int SEQ_CNT_W = 3;

  // APB register map, byte addresses
  localparam int APB_ADDR_W = 8;
  localparam logic [APB_ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [APB_ADDR_W-1:0] THRESH_OFFSET = 8'h04;
  localparam logic [APB_ADDR_W-1:0] DOUT_RESET_OFFSET = 8'h08;
  localparam logic [APB_ADDR_W-1:0] STATUS_OFFSET = 8'h0C;
  localparam logic [APB_ADDR_W-1:0] LEVEL_OFFSET = 8'h10;

  // Control register layout
  typedef struct packed {
    logic [22:0] unused;
    logic sync_clear;
    logic [2:0] rsvd;
    logic clear_enable;
    logic shift_storage;
    logic embedded_reg;
    logic safety_circuit;
    logic full_flags_high;
  } ctrl_type;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0011;
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000_001F;
  localparam logic [31:0] THRESH_RESET = 32'h0002_000E;
  localparam logic [31:0] DOUT_RESET_RESET = 32'h0000_0000;

  // Threshold fields
  localparam int THR_W = 16;
  localparam int THR_HI_LSB = 0;
  localparam int THR_LO_LSB = 16;

  // Status bit positions
  localparam int ST_NOTHING_STORED = 0;
  localparam int ST_NEAR_DRAINED = 1;
  localparam int ST_THRESH_LOW = 2;
  localparam int ST_NO_ROOM = 3;
  localparam int ST_NEAR_CAPACITY = 4;
  localparam int ST_THRESH_HIGH = 5;
  localparam int ST_CLEARING = 6;
  localparam int ST_IN_RESET = 7;
  localparam int STATUS_W = 8;

  typedef enum {ST_RUN, ST_SYNC, ST_HOLD} clr_state_type;

endpackage

// ---- hdl/common_clock_fifo_reset_logic.sv ----
// What this block does
// - Built-in variant behaves alike on one clock
// - One clock, two pointers, optional clear kinds
// - Shift storage uses one up/down counter
// - Clear resets counters; optional for RAM storage
// - Clear resets state, synchronised into domain
// - Safety circuit needs embedded output register
// - Clear acts on rising edge only
// - Reset release takes five clock cycles, two with full flags low
// - Flag rejected reads and writes; with full flags low, writes refused during reset are not flagged
// - Full-type flags high or low during reset
// - Reset values of data, empties, counts
// - Full flags high block writes during reset
// - Synchronisation lasts three clock periods
// - Full flags drop five cycles after release
// - Low option: writable five cycles after edge
`timescale 1ns/10ps
module common_clock_fifo_reset_logic #(
  parameter int DEPTH = fifo_reset_pkg::DEPTH_DEFAULT,
  parameter int WIDTH = fifo_reset_pkg::WIDTH_DEFAULT
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Clear pin
  input wire logic async_clear_i,
  // APB slave
  input wire logic [fifo_reset_pkg::APB_ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Write side
  input wire logic write_request_i,
  input wire logic [WIDTH-1:0] write_word_i,
  output logic write_accepted_o,
  output logic write_rejected_o,
  output logic no_room_o,
  output logic near_capacity_o,
  output logic threshold_high_o,
  output logic write_side_clearing_o,
  output logic [$clog2(DEPTH):0] write_level_o,
  // Read side
  input wire logic read_request_i,
  output logic [WIDTH-1:0] read_word_o,
  output logic read_valid_o,
  output logic read_rejected_o,
  output logic nothing_stored_o,
  output logic near_drained_o,
  output logic threshold_low_o,
  output logic [$clog2(DEPTH):0] read_level_o
);
  import fifo_reset_pkg::*;

  localparam int ADDR_W = $clog2(DEPTH);
  localparam int LVL_W = ADDR_W + 1;
  localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);
  localparam logic [LVL_W-1:0] NEAR_FULL_LVL = LVL_W'(DEPTH - 1);
  localparam logic [LVL_W-1:0] NEAR_EMPTY_LVL = LVL_W'(1);
  localparam logic [SEQ_CNT_W-1:0] SYNC_LAST = SEQ_CNT_W'(RESET_SYNC_CYCLES - 1);
  localparam logic [SEQ_CNT_W-1:0] HIGH_HOLD_LAST = SEQ_CNT_W'(FULL_RELEASE_CYCLES - 1);
  localparam logic [SEQ_CNT_W-1:0] LOW_HOLD_LAST = SEQ_CNT_W'(WRITABLE_AFTER_ASSERT - RESET_SYNC_CYCLES - 1);

  function automatic logic [THR_W-1:0] widen_level(input logic [LVL_W-1:0] lvl);
    widen_level = {{(THR_W - LVL_W){1'b0}}, lvl};
  endfunction

  // Configuration registers
  ctrl_type ctrl_q;
  logic [31:0] thresh_q;
  logic [31:0] dout_rst_q;

  // Clear pin synchroniser and edge detector
  logic clr_meta_q;
  logic clr_sync_q;
  logic clr_prev_q;

  // Sequencer
  clr_state_type st_q;
  logic [SEQ_CNT_W-1:0] cnt_q;

  // Storage and counters
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [LVL_W-1:0] wr_ptr_q;
  logic [LVL_W-1:0] rd_ptr_q;
  logic [LVL_W-1:0] count_q;
  logic [WIDTH-1:0] read_word_q;
  logic read_valid_q;
  logic write_accepted_q;
  logic write_rejected_q;
  logic read_rejected_q;
  logic [31:0] prdata_q;

  // Bus decode
  wire apb_setup = psel_i & ~penable_i;
  wire apb_access = psel_i & penable_i;
  wire hit_ctrl = paddr_i == CTRL_OFFSET;
  wire hit_thresh = paddr_i == THRESH_OFFSET;
  wire hit_dout = paddr_i == DOUT_RESET_OFFSET;
  wire hit_status = paddr_i == STATUS_OFFSET;
  wire hit_level = paddr_i == LEVEL_OFFSET;
  wire addr_hit = hit_ctrl | hit_thresh | hit_dout | hit_status | hit_level;
  wire apb_wr = apb_access & pwrite_i & addr_hit;
  wire ctrl_type wr_ctrl = ctrl_type'(pwdata_i);
  wire sync_clear = apb_wr & hit_ctrl & wr_ctrl.sync_clear;

  // A RAM-backed queue may run with the clear pin ignored
  wire clear_honoured = ctrl_q.clear_enable | ctrl_q.shift_storage;
  wire clear_hit = clr_sync_q & ~clr_prev_q & clear_honoured;
  wire in_reset = st_q != ST_RUN;
  wire safety_on = ctrl_q.safety_circuit & ctrl_q.embedded_reg;

  // Level: shared counter for shift storage, pointer distance for RAM
  wire [LVL_W-1:0] ptr_level = LVL_W'(wr_ptr_q - rd_ptr_q);
  wire [LVL_W-1:0] level = ctrl_q.shift_storage ? count_q : ptr_level;
  wire [THR_W-1:0] thr_hi = thresh_q[THR_HI_LSB +: THR_W];
  wire [THR_W-1:0] thr_lo = thresh_q[THR_LO_LSB +: THR_W];

  // Flags; counters are already zero while in reset
  wire empty_w = in_reset | (level == '0);
  wire full_w = in_reset ? ctrl_q.full_flags_high : (level == FULL_LVL);
  wire near_full_w = in_reset ? ctrl_q.full_flags_high : (level >= NEAR_FULL_LVL);
  wire thr_high_w = in_reset ? ctrl_q.full_flags_high : (widen_level(level) >= thr_hi);
  wire near_empty_w = in_reset | (level <= NEAR_EMPTY_LVL);
  wire thr_low_w = in_reset | (widen_level(level) <= thr_lo);

  wire wr_ok = write_request_i & ~in_reset & ~full_w;
  wire rd_ok = read_request_i & ~empty_w;
  wire [ADDR_W-1:0] rd_idx = ctrl_q.shift_storage ? ADDR_W'(count_q - 1'b1) : rd_ptr_q[ADDR_W-1:0];
  wire [WIDTH-1:0] dout_rst_val = dout_rst_q[WIDTH-1:0];

  // Sequencer control
  wire hold_last = ctrl_q.full_flags_high ? (cnt_q == HIGH_HOLD_LAST) : (cnt_q == LOW_HOLD_LAST);
  // High option waits for the pin to drop before counting
  wire hold_count = ~ctrl_q.full_flags_high | ~clr_sync_q;

  wire [STATUS_W-1:0] status_w = {in_reset, write_side_clearing_o, thr_high_w, near_full_w, full_w,
                                  thr_low_w, near_empty_w, empty_w};
  wire [31:0] rdata_mux = hit_ctrl ? (32'(ctrl_q) & CTRL_WRITE_MASK)
                        : hit_thresh ? thresh_q
                        : hit_dout ? dout_rst_q
                        : hit_status ? 32'(status_w)
                        : hit_level ? 32'(level)
                        : 32'h0000_0000;

  // Single domain: the built-in style is the same logic on this clock
  always_ff @(posedge ref_clk_i)
  begin
    clr_meta_q <= async_clear_i;
    clr_sync_q <= clr_meta_q;
    if (reset_i)
      clr_prev_q <= 1'b0;
    else
      clr_prev_q <= clr_sync_q;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      ctrl_q <= ctrl_type'(CTRL_RESET);
      thresh_q <= THRESH_RESET;
      dout_rst_q <= DOUT_RESET_RESET;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      if (apb_wr & hit_ctrl)
        ctrl_q <= ctrl_type'(pwdata_i & CTRL_WRITE_MASK);
      if (apb_wr & hit_thresh)
        thresh_q <= pwdata_i;
      if (apb_wr & hit_dout)
        dout_rst_q <= pwdata_i;
      if (apb_setup)
        prdata_q <= rdata_mux;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      st_q <= ST_RUN;
      cnt_q <= '0;
    end
    else if (clear_hit)
    begin
      st_q <= ST_SYNC;
      cnt_q <= '0;
    end
    else
    begin
      unique case (st_q)
        ST_RUN:
          cnt_q <= '0;
        ST_SYNC:
          if (cnt_q == SYNC_LAST)
          begin
            st_q <= ST_HOLD;
            cnt_q <= '0;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        ST_HOLD:
          if (hold_count & hold_last)
          begin
            st_q <= ST_RUN;
            cnt_q <= '0;
          end
          else if (hold_count)
            cnt_q <= cnt_q + 1'b1;
      endcase
    end
  end

  // Counters, read word and valid/accepted flags return to reset values; reject flags reset only on reset_i
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i | in_reset | clear_hit | sync_clear)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      read_word_q <= dout_rst_val;
      read_valid_q <= 1'b0;
      write_accepted_q <= 1'b0;
    end
    else
    begin
      if (wr_ok)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (rd_ok)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      if (wr_ok & ~rd_ok)
        count_q <= count_q + 1'b1;
      else if (rd_ok & ~wr_ok)
        count_q <= count_q - 1'b1;
      if (rd_ok)
        read_word_q <= mem_q[rd_idx];
      read_valid_q <= rd_ok;
      write_accepted_q <= wr_ok;
    end
    if (reset_i)
    begin
      write_rejected_q <= 1'b0;
      read_rejected_q <= 1'b0;
    end
    else
    begin
      write_rejected_q <= write_request_i & full_w;
      read_rejected_q <= read_request_i & empty_w;
    end
  end

  // Storage itself is not reset; counters make stale words unreachable
  always_ff @(posedge ref_clk_i)
  begin
    if (wr_ok & ctrl_q.shift_storage)
    begin
      mem_q[0] <= write_word_i;
      for (int i = 1; i < DEPTH; i++)
        mem_q[i] <= mem_q[i-1];
    end
    else if (wr_ok)
      mem_q[wr_ptr_q[ADDR_W-1:0]] <= write_word_i;
  end

  assign pready_o = apb_access;
  assign pslverr_o = apb_access & ~addr_hit;
  assign prdata_o = prdata_q;
  assign write_accepted_o = write_accepted_q;
  assign write_rejected_o = write_rejected_q;
  assign read_rejected_o = read_rejected_q;
  assign read_valid_o = read_valid_q;
  assign read_word_o = read_word_q;
  assign no_room_o = full_w;
  assign near_capacity_o = near_full_w;
  assign threshold_high_o = thr_high_w;
  assign nothing_stored_o = empty_w;
  assign near_drained_o = near_empty_w;
  assign threshold_low_o = thr_low_w;
  assign write_level_o = level;
  assign read_level_o = level;
  assign write_side_clearing_o = safety_on & in_reset;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  a_edge_starts_reset: assert property (clear_hit |=> st_q == ST_SYNC) else $error("clear edge missed");
  a_level_no_retrigger: assert property (st_q == ST_RUN && !clear_hit |=> st_q == ST_RUN)
    else $error("reset entered without edge");
  a_sync_three_cycles: assert property (st_q == ST_SYNC && cnt_q == '0 && !clear_hit ##1 !clear_hit ##1 !clear_hit
    |=> st_q == ST_HOLD) else $error("sync window not three cycles");
  a_full_high_reset: assert property (in_reset && ctrl_q.full_flags_high
    |-> no_room_o && near_capacity_o && threshold_high_o) else $error("full flags low in reset");
  a_full_low_reset: assert property (in_reset && !ctrl_q.full_flags_high
    |-> !no_room_o && !near_capacity_o && !threshold_high_o) else $error("full flags high in reset");
  a_empty_in_reset: assert property (in_reset |=> nothing_stored_o && near_drained_o && threshold_low_o
    && write_level_o == '0 && !read_valid_o && !write_accepted_o) else $error("bad reset outputs");
  a_dout_in_reset: assert property (in_reset |=> read_word_o == $past(dout_rst_val))
    else $error("read word not reset value");
  a_release_five: assert property (st_q == ST_HOLD && cnt_q == '0 && ctrl_q.full_flags_high && !clr_sync_q
    && !clear_hit ##1 (!clear_hit && !clr_sync_q && ctrl_q.full_flags_high)[*4] |=> st_q == ST_RUN)
    else $error("full flags not released after five");
  a_write_reject: assert property (write_request_i && no_room_o |=> write_rejected_o)
    else $error("write reject missing");
  a_read_reject: assert property (read_request_i && nothing_stored_o |=> read_rejected_o && !read_valid_o)
    else $error("read reject missing");
  a_safety_embedded: assert property (write_side_clearing_o |-> ctrl_q.embedded_reg && in_reset)
    else $error("clearing flag without embedded reg");

endmodule

// ---- tb/queue_user_model.sv ----
`timescale 1ns/10ps
module queue_user_model #(
  parameter int WIDTH = 32
) (
  // Clock
  input wire logic clk_i,
  // Queue side
  input wire logic clearing_i,
  output logic write_request_o,
  output logic [WIDTH-1:0] write_word_o,
  output logic read_request_o,
  output logic async_clear_o
);
  initial
  begin
    write_request_o = 1'b0;
    write_word_o = '0;
    read_request_o = 1'b0;
    async_clear_o = 1'b0;
  end

  // Tasks never run together, so requests stay quiet while a clear is high
  task automatic push(input int n, input logic [WIDTH-1:0] base);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      write_request_o <= 1'b1;
      write_word_o <= base + WIDTH'(i);
    end
    @(posedge clk_i);
    write_request_o <= 1'b0;
    write_word_o <= ~write_word_o;
  endtask

  task automatic pull(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      read_request_o <= 1'b1;
    end
    @(posedge clk_i);
    read_request_o <= 1'b0;
  endtask

  // Clock runs throughout, so one clear is always enough
  task automatic clear(input int hold);
    int k;
    k = 0;
    if (hold < 3)
      hold = 3;
    @(posedge clk_i);
    async_clear_o <= 1'b1;
    repeat (hold) @(posedge clk_i);
    async_clear_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    while (clearing_i !== 1'b0 && k < 50)
    begin
      @(posedge clk_i);
      k++;
    end
  endtask
endmodule

// ---- tb/common_clock_fifo_reset_logic_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module common_clock_fifo_reset_logic_tb_top;
  import fifo_reset_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} row_type;
  int fail_count = 0;
  int checked = 0;
  int acc_n = 0;
  int wrej_n = 0;
  int rrej_n = 0;
  logic [31:0] exp_q[$];
  logic clk = 1'b0;
  logic rst, psel, penable, pwrite, pready, pslverr, aclr, wreq, rreq, clearing;
  logic wacc, wrej, noroom, ncap, thi, rvalid, rrej, nstored, ndrained, tlo;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, wword, rword, exp_w;
  logic [4:0] wl, rl;
  row_type rows [14] = '{'{1'b0, CTRL_OFFSET, 32'h0, CTRL_RESET, 1'b0},
    '{1'b0, THRESH_OFFSET, 32'h0, THRESH_RESET, 1'b0}, '{1'b0, DOUT_RESET_OFFSET, 32'h0, 32'h0, 1'b0},
    '{1'b0, STATUS_OFFSET, 32'h0, 32'h07, 1'b0}, '{1'b0, LEVEL_OFFSET, 32'h0, 32'h0, 1'b0},
    '{1'b1, 8'h14, 32'h1, 32'h0, 1'b1}, '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1},
    '{1'b1, STATUS_OFFSET, 32'hFF, 32'h0, 1'b0}, '{1'b0, STATUS_OFFSET, 32'h0, 32'h07, 1'b0},
    '{1'b1, DOUT_RESET_OFFSET, 32'hA5, 32'h0, 1'b0}, '{1'b0, DOUT_RESET_OFFSET, 32'h0, 32'hA5, 1'b0},
    '{1'b1, CTRL_OFFSET, 32'hFFFFFFFF, 32'h0, 1'b0}, '{1'b0, CTRL_OFFSET, 32'h0, 32'h1F, 1'b0},
    '{1'b1, CTRL_OFFSET, 32'h11, 32'h0, 1'b0}};

  always #25 clk = ~clk;

  common_clock_fifo_reset_logic i_dut (.ref_clk_i(clk), .reset_i(rst),
    .async_clear_i(aclr), .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .write_request_i(wreq),
    .write_word_i(wword), .write_accepted_o(wacc), .write_rejected_o(wrej), .no_room_o(noroom),
    .near_capacity_o(ncap), .threshold_high_o(thi), .write_side_clearing_o(clearing), .write_level_o(wl),
    .read_request_i(rreq), .read_word_o(rword), .read_valid_o(rvalid), .read_rejected_o(rrej),
    .nothing_stored_o(nstored), .near_drained_o(ndrained), .threshold_low_o(tlo), .read_level_o(rl));

  queue_user_model i_user (.clk_i(clk), .clearing_i(clearing), .write_request_o(wreq),
    .write_word_o(wword), .read_request_o(rreq), .async_clear_o(aclr));

  always @(posedge clk)
  begin
    if (wacc === 1'b1) acc_n++;
    if (wrej === 1'b1) wrej_n++;
    if (rrej === 1'b1) rrej_n++;
    // Pop once, so a mismatch does not consume a second word
    if (rvalid === 1'b1)
    begin
      `CHK(32'(exp_q.size()) != 32'h0, 1'b1)
      if (exp_q.size() != 0)
      begin
        exp_w = exp_q.pop_front();
        `CHK(rword, exp_w)
      end
    end
  end

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fail_count++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int n, input logic [31:0] base);
    for (int i = 0; i < n; i++)
      exp_q.push_back(base + 32'(i));
    i_user.push(n, base);
  endtask

  // Clearing flag checked against exp mid-sequence, then gone once the model returns
  task automatic clr_chk(input logic exp);
    fork
      i_user.clear(3);
      begin
        repeat (6) @(posedge clk);
        #1;
        `CHK(clearing, exp)
      end
    join
    `CHK(clearing, 1'b0)
  endtask

  initial
  begin
    logic [31:0] rd;
    logic err;
    int n;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({nstored, ndrained, tlo, wl, rword}, {3'b111, 5'h00, 32'h0})
    `CHK({noroom, ncap, thi, wacc, rvalid}, 5'h00)
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d, rd, err);
      `CHK(err, rows[i].err)
      if (!rows[i].w) `CHK(rd, rows[i].e)
    end
    wr(16, 32'h100);
    @(posedge clk);
    #1;
    `CHK({noroom, ncap, thi, wl, 32'(acc_n)}, {3'b111, 5'h10, 32'h10})
    i_user.push(1, 32'hDEAD);
    i_user.pull(17);
    @(posedge clk);
    #1;
    `CHK({32'(wrej_n), 32'(rrej_n), 32'(exp_q.size()), nstored}, {32'h1, 32'h1, 32'h0, 1'b1})
    wr(2, 32'h200);
    fork
      i_user.clear(3);
      begin
        repeat (6) @(posedge clk);
        #1;
        `CHK({noroom, ncap, thi}, 3'b111)
        `CHK({nstored, rl, rword}, {1'b1, 5'h00, 32'hA5})
        n = 0;
        while (noroom !== 1'b0 && n < 40)
        begin
          @(posedge clk);
          n++;
        end
        `CHK(n + 2 >= 5 && n + 2 <= 10, 1'b1)
      end
    join
    exp_q.delete();
    apb(1'b1, CTRL_OFFSET, 32'h10, rd, err);
    fork
      i_user.clear(20);
      begin
        repeat (6) @(posedge clk);
        #1;
        `CHK({noroom, nstored}, 2'b01)
        repeat (8) @(posedge clk);
        apb(1'b0, STATUS_OFFSET, 32'h0, rd, err);
        `CHK(rd[ST_IN_RESET], 1'b0)
      end
    join
    wr(1, 32'h300);
    i_user.pull(1);
    @(posedge clk);
    #1;
    `CHK(32'(exp_q.size()), 32'h0)
    apb(1'b1, CTRL_OFFSET, 32'h17, rd, err);
    clr_chk(1'b1);
    apb(1'b1, CTRL_OFFSET, 32'h13, rd, err);
    clr_chk(1'b0);
    // RAM storage with the clear pin disabled keeps its contents
    apb(1'b1, CTRL_OFFSET, 32'h01, rd, err);
    wr(1, 32'h600);
    i_user.clear(3);
    `CHK({wl, nstored}, {5'h01, 1'b0})
    i_user.pull(1);
    // Shift storage, entered through a write-one clear
    apb(1'b1, CTRL_OFFSET, 32'h118, rd, err);
    wr(3, 32'h400);
    #1;
    `CHK(wl, 5'h03)
    i_user.pull(3);
    @(posedge clk);
    #1;
    `CHK(32'(exp_q.size()), 32'h0)
    // Mid-run reset with words stored
    i_user.push(2, 32'h500);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({wl, rword, nstored, noroom}, {5'h00, 32'h0, 1'b1, 1'b0})
    apb(1'b0, CTRL_OFFSET, 32'h0, rd, err);
    `CHK(rd, CTRL_RESET)
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule
